// ==== rtl/fps_protect.sv ====
`include "fps_regs.svh"
`default_nettype none
module fps_protect
   import fps_pkg::*;
#(
   parameter bit LARGE_DENSITY = 1'b1
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic si,
   output logic so,
   output logic so_oe,
   input wire logic [7:0] region_mode,
   output logic pe_start,
   output logic pe_denied,
   output logic [31:0] pe_addr,
   output logic [7:0] lock_status,
   output logic [31:0] pointer_config
);
   fps_link_if lnk_i();

   logic rx_tog_s;
   logic cs_n_s;
   logic rx_tog_d_reg;
   logic cs_n_d_reg;
   logic exec_reg;
   fps_state_type state_reg;
   fps_state_type state_next;
   fps_cmd_type cmd_reg;
   fps_cmd_type cmd_next;
   logic [31:0] addr_reg;
   logic [31:0] addr_next;
   logic [2:0] cnt_reg;
   logic [2:0] cnt_next;
   logic [7:0] data_reg;
   logic [7:0] data_next;
   logic [7:0] tx_reg;
   logic [7:0] tx_next;
   logic cfg_lock_reg;
   logic cfg_lock_next;
   logic init_pend_reg;
   logic [`FPS_BLOCKS-1:0] unlocked_reg;
   logic [`FPS_BLOCKS-1:0] unlocked_next;
   logic [31:0] ptr_reg;
   logic [31:0] ptr_next;
   logic pe_start_reg;
   logic pe_denied_reg;
   logic [31:0] pe_addr_reg;
   logic [7:0] lsr_reg;

   fps_spi_link u_link (
      .sck(sck),
      .cs_n(cs_n),
      .reset_n(reset_n),
      .si(si),
      .so(so),
      .so_oe(so_oe),
      .lnk(lnk_i.link)
   );

   fps_sync #(.RESET_VAL(1'b0)) u_sync_tog (
      .clk(clk),
      .reset_n(reset_n),
      .d(lnk_i.rx_toggle),
      .q(rx_tog_s)
   );

   fps_sync #(.RESET_VAL(1'b1)) u_sync_cs (
      .clk(clk),
      .reset_n(reset_n),
      .d(cs_n),
      .q(cs_n_s)
   );

   function automatic fps_cmd_type decode_cmd(input logic [7:0] op);
      fps_cmd_type c;
      case (op)
         `FPS_OP_LSR_READ: c = FPS_CMD_LSR_READ;
         `FPS_OP_LSR_LOCK: c = FPS_CMD_LSR_LOCK;
         `FPS_OP_READ_ANY_REGISTER: c = FPS_CMD_READ_ANY_REGISTER;
         `FPS_OP_WRITE_ANY_REGISTER: c = FPS_CMD_WRITE_ANY_REGISTER;
         `FPS_OP_SL_READ: c = FPS_CMD_SL_READ;
         `FPS_OP_SL_READ4: c = FPS_CMD_SL_READ;
         `FPS_OP_SL_LOCK: c = FPS_CMD_SL_LOCK;
         `FPS_OP_SL_LOCK4: c = FPS_CMD_SL_LOCK;
         `FPS_OP_SL_UNLOCK: c = FPS_CMD_SL_UNLOCK;
         `FPS_OP_SL_UNLOCK4: c = FPS_CMD_SL_UNLOCK;
         `FPS_OP_GLOCK: c = FPS_CMD_GLOCK;
         `FPS_OP_GUNLOCK: c = FPS_CMD_GUNLOCK;
         `FPS_OP_PTR_SET: c = FPS_CMD_PTR_SET;
         `FPS_OP_PTR_SET4: c = FPS_CMD_PTR_SET;
         `FPS_OP_PP: c = FPS_CMD_PROG_ERASE;
         `FPS_OP_PP4: c = FPS_CMD_PROG_ERASE;
         `FPS_OP_SE: c = FPS_CMD_PROG_ERASE;
         `FPS_OP_SE4: c = FPS_CMD_PROG_ERASE;
         `FPS_OP_BE: c = FPS_CMD_PROG_ERASE;
         `FPS_OP_BE4: c = FPS_CMD_PROG_ERASE;
         default: c = FPS_CMD_NONE;
      endcase
      return c;
   endfunction

   // number of address bytes that follow the opcode
   function automatic logic [2:0] addr_len(input logic [7:0] op);
      logic [2:0] n;
      case (op)
         `FPS_OP_SL_READ4,
         `FPS_OP_SL_LOCK4,
         `FPS_OP_SL_UNLOCK4,
         `FPS_OP_PTR_SET4,
         `FPS_OP_PP4,
         `FPS_OP_SE4,
         `FPS_OP_BE4: n = 3'h4;
         `FPS_OP_READ_ANY_REGISTER,
         `FPS_OP_WRITE_ANY_REGISTER,
         `FPS_OP_SL_READ,
         `FPS_OP_SL_LOCK,
         `FPS_OP_SL_UNLOCK,
         `FPS_OP_PTR_SET,
         `FPS_OP_PP,
         `FPS_OP_SE,
         `FPS_OP_BE: n = 3'h3;
         default: n = 3'h0;
      endcase
      return n;
   endfunction

   // reserved bits always read as erased ones
   function automatic logic [31:0] fix_ptr(input logic [31:0] v);
      logic [31:0] r;
      r = v | `FPS_PTR_RSVD_ONES;
      if (!LARGE_DENSITY) begin
         r[`FPS_PTR_A24_BIT] = 1'b1;
      end
      return r;
   endfunction

   function automatic logic ptr_hit(
      input logic [31:0] p,
      input logic [31:0] a
   );
      logic [12:0] pa;
      logic [12:0] aa;
      logic hit;
      pa = p[24:12];
      aa = a[24:12];
      if (!LARGE_DENSITY) begin
         pa[12] = 1'b0;
         aa[12] = 1'b0;
      end
      if (p[`FPS_PTR_EN_N_BIT]) begin
         hit = 1'b0;
      end else if (p[`FPS_PTR_ALL_BIT]) begin
         hit = 1'b1;
      end else if (p[`FPS_PTR_BOTTOM_BIT]) begin
         hit = (aa <= pa);
      end else begin
         hit = (aa >= pa);
      end
      return hit;
   endfunction

   function automatic logic [7:0] get_byte(
      input logic [31:0] v,
      input logic [1:0] sel
   );
      logic [7:0] b;
      case (sel)
         2'h0: b = v[7:0];
         2'h1: b = v[15:8];
         2'h2: b = v[23:16];
         default: b = v[31:24];
      endcase
      return b;
   endfunction

   function automatic logic [31:0] put_byte(
      input logic [31:0] v,
      input logic [1:0] sel,
      input logic [7:0] b
   );
      logic [31:0] r;
      r = v;
      case (sel)
         2'h0: r[7:0] = b;
         2'h1: r[15:8] = b;
         2'h2: r[23:16] = b;
         default: r[31:24] = b;
      endcase
      return r;
   endfunction

   // byte events and frame edges from the link domain
   wire byte_stb = rx_tog_s ^ rx_tog_d_reg;
   wire frame_start = cs_n_d_reg & ~cs_n_s;
   wire frame_end = cs_n_s & ~cs_n_d_reg;
   wire [7:0] rx = lnk_i.rx_byte;
   wire [31:0] addr_shift = {addr_reg[23:0], rx};
   wire [8:0] blk_idx = addr_reg[24:16];
   wire [8:0] blk_shift = addr_shift[24:16];
   wire is_lsr_addr = addr_shift[23:0] == `FPS_REG_ADDR_LSR;
   wire is_ptr_addr = addr_shift[23:2] == 22'(`FPS_REG_ADDR_PTR >> 2);
   wire wr_ptr_addr = addr_reg[23:2] == 22'(`FPS_REG_ADDR_PTR >> 2);
   wire addr_ok = state_reg == FPS_ST_DATA || state_reg == FPS_ST_SKIP;
   wire data_ok = state_reg == FPS_ST_SKIP;
   wire mode_open = region_mode[`FPS_MODE_PWD_BIT] &
      region_mode[`FPS_MODE_PERM_BIT];
   wire boot_locked = region_mode[`FPS_MODE_BOOT_BIT];

   logic [7:0] lsr_value;
   always_comb begin
      lsr_value = 8'h00;
      lsr_value[`FPS_LSR_CFG_LOCK_BIT] = cfg_lock_reg;
      lsr_value[`FPS_LSR_R3PW_BIT] =
         region_mode[`FPS_MODE_R3PW_BIT];
   end

   // value returned once the last address byte has arrived
   logic [7:0] rd_data;
   always_comb begin
      rd_data = 8'h00;
      case (cmd_reg)
         FPS_CMD_SL_READ: rd_data = unlocked_reg[blk_shift] ?
            `FPS_LOCK_OFF : `FPS_LOCK_ON;
         FPS_CMD_READ_ANY_REGISTER: begin
            if (is_lsr_addr) begin
               rd_data = lsr_value;
            end else if (is_ptr_addr) begin
               rd_data = get_byte(ptr_reg, addr_shift[1:0]);
            end
         end
         default: rd_data = 8'h00;
      endcase
   end

   // commands take effect when the frame closes, as the link requires
   wire do_sl_lock = exec_reg & addr_ok & (cmd_reg == FPS_CMD_SL_LOCK);
   wire do_sl_unlock = exec_reg & addr_ok & (cmd_reg == FPS_CMD_SL_UNLOCK);
   wire do_glock = exec_reg & (cmd_reg == FPS_CMD_GLOCK);
   wire do_gunlock = exec_reg & (cmd_reg == FPS_CMD_GUNLOCK);
   wire do_cfg_lock = exec_reg & (cmd_reg == FPS_CMD_LSR_LOCK);
   wire do_ptr_set = exec_reg & addr_ok & (cmd_reg == FPS_CMD_PTR_SET) &
      cfg_lock_reg;
   wire do_ptr_write_any_register = exec_reg & data_ok & (cmd_reg == FPS_CMD_WRITE_ANY_REGISTER) &
      wr_ptr_addr & cfg_lock_reg;
   wire do_pe = exec_reg & addr_ok & (cmd_reg == FPS_CMD_PROG_ERASE);
   wire pe_blocked = ~unlocked_reg[blk_idx] | ptr_hit(ptr_reg, addr_reg);

   // cnt_reg is spent by the time the frame closes, so keep the form
   logic wide_addr_reg;
   wire op_stb = byte_stb & ~frame_start & ~exec_reg &
      (state_reg == FPS_ST_IDLE);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wide_addr_reg <= 1'b0;
      end else if (op_stb) begin
         wide_addr_reg <= addr_len(rx) == 3'h4;
      end
   end

   // 3-byte set command forces the whole top byte, A24 bit included, to ones
   wire [31:0] ptr_set_value = wide_addr_reg ?
      addr_reg : {8'hFF, addr_reg[23:0]};

   always_comb begin
      state_next = state_reg;
      cmd_next = cmd_reg;
      addr_next = addr_reg;
      cnt_next = cnt_reg;
      data_next = data_reg;
      tx_next = tx_reg;
      if (frame_start) begin
         state_next = FPS_ST_IDLE;
         cmd_next = FPS_CMD_NONE;
         tx_next = 8'h00;
      end else if (exec_reg) begin
         state_next = FPS_ST_IDLE;
         cmd_next = FPS_CMD_NONE;
      end else if (byte_stb) begin
         case (state_reg)
            FPS_ST_IDLE: begin
               cmd_next = decode_cmd(rx);
               addr_next = 32'h0000_0000;
               cnt_next = addr_len(rx);
               if (decode_cmd(rx) == FPS_CMD_NONE) begin
                  state_next = FPS_ST_SKIP;
               end else if (addr_len(rx) == 3'h0) begin
                  state_next = FPS_ST_DATA;
               end else begin
                  state_next = FPS_ST_ADDR;
               end
               if (decode_cmd(rx) == FPS_CMD_LSR_READ) begin
                  tx_next = lsr_value;
               end
            end
            FPS_ST_ADDR: begin
               addr_next = addr_shift;
               cnt_next = cnt_reg - 3'h1;
               if (cnt_reg == 3'h1) begin
                  state_next = FPS_ST_DATA;
                  tx_next = rd_data;
               end
            end
            FPS_ST_DATA: begin
               // lock status writes land here and are dropped
               data_next = rx;
               state_next = FPS_ST_SKIP;
            end
            default: state_next = FPS_ST_SKIP;
         endcase
      end
   end

   always_comb begin
      unlocked_next = unlocked_reg;
      if (init_pend_reg) begin
         unlocked_next = {`FPS_BLOCKS{~boot_locked}};
      end else if (do_glock) begin
         unlocked_next = '0;
      end else if (do_gunlock) begin
         unlocked_next = '1;
      end else if (do_sl_lock) begin
         unlocked_next[blk_idx] = 1'b0;
      end else if (do_sl_unlock) begin
         unlocked_next[blk_idx] = 1'b1;
      end
   end

   always_comb begin
      ptr_next = ptr_reg;
      if (do_ptr_set) begin
         ptr_next = fix_ptr(ptr_set_value);
      end else if (do_ptr_write_any_register) begin
         ptr_next = fix_ptr(put_byte(ptr_reg, addr_reg[1:0], data_reg));
      end
   end

   // permanent and password modes keep the lock closed for good
   always_comb begin
      cfg_lock_next = cfg_lock_reg;
      if (init_pend_reg) begin
         cfg_lock_next = mode_open;
      end else if (do_cfg_lock && mode_open) begin
         cfg_lock_next = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_tog_d_reg <= 1'b0;
         cs_n_d_reg <= 1'b1;
         exec_reg <= 1'b0;
         init_pend_reg <= 1'b1;
      end else begin
         rx_tog_d_reg <= rx_tog_s;
         cs_n_d_reg <= cs_n_s;
         exec_reg <= frame_end;
         init_pend_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= FPS_ST_IDLE;
         cmd_reg <= FPS_CMD_NONE;
         addr_reg <= 32'h0000_0000;
         cnt_reg <= 3'h0;
         data_reg <= 8'h00;
         tx_reg <= 8'h00;
      end else begin
         state_reg <= state_next;
         cmd_reg <= cmd_next;
         addr_reg <= addr_next;
         cnt_reg <= cnt_next;
         data_reg <= data_next;
         tx_reg <= tx_next;
      end
   end

   // protected until the mode bits are sampled one cycle after release
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         unlocked_reg <= '0;
         cfg_lock_reg <= 1'b0;
         ptr_reg <= `FPS_PTR_RESET;
         lsr_reg <= 8'h00;
      end else begin
         unlocked_reg <= unlocked_next;
         cfg_lock_reg <= cfg_lock_next;
         ptr_reg <= fix_ptr(ptr_next);
         lsr_reg <= lsr_value;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pe_start_reg <= 1'b0;
         pe_denied_reg <= 1'b0;
         pe_addr_reg <= 32'h0000_0000;
      end else begin
         pe_start_reg <= do_pe & ~pe_blocked;
         pe_denied_reg <= do_pe & pe_blocked;
         if (do_pe) begin
            pe_addr_reg <= addr_reg;
         end
      end
   end

   assign lnk_i.tx_byte = tx_reg;
   assign pe_start = pe_start_reg;
   assign pe_denied = pe_denied_reg;
   assign pe_addr = pe_addr_reg;
   assign lock_status = lsr_reg;
   assign pointer_config = ptr_reg;
endmodule
`default_nettype wire

// ==== rtl/fps_regs.svh ====
`ifndef FPS_REGS_SVH
`define FPS_REGS_SVH
`define FPS_OP_LSR_READ 8'hA7
`define FPS_OP_LSR_LOCK 8'hA6
`define FPS_OP_READ_ANY_REGISTER 8'h65
`define FPS_OP_WRITE_ANY_REGISTER 8'h71
`define FPS_OP_SL_READ 8'h3D
`define FPS_OP_SL_READ4 8'hE0
`define FPS_OP_SL_LOCK 8'h36
`define FPS_OP_SL_LOCK4 8'hE1
`define FPS_OP_SL_UNLOCK 8'h39
`define FPS_OP_SL_UNLOCK4 8'hE2
`define FPS_OP_GLOCK 8'h7E
`define FPS_OP_GUNLOCK 8'h98
`define FPS_OP_PTR_SET 8'hFB
`define FPS_OP_PTR_SET4 8'hE3
`define FPS_OP_PP 8'h02
`define FPS_OP_PP4 8'h12
`define FPS_OP_SE 8'h20
`define FPS_OP_SE4 8'h21
`define FPS_OP_BE 8'hD8
`define FPS_OP_BE4 8'hDC
`define FPS_LSR_CFG_LOCK_BIT 0
`define FPS_LSR_R3PW_BIT 6
`define FPS_MODE_PERM_BIT 0
`define FPS_MODE_PWD_BIT 2
`define FPS_MODE_BOOT_BIT 4
`define FPS_MODE_R3PW_BIT 6
`define FPS_PTR_BOTTOM_BIT 9
`define FPS_PTR_EN_N_BIT 10
`define FPS_PTR_ALL_BIT 11
`define FPS_PTR_A24_BIT 24
`define FPS_PTR_RESET 32'hFFFF_FFFF
`define FPS_PTR_RSVD_ONES 32'hFE00_01FF
`define FPS_LOCK_ON 8'h00
`define FPS_LOCK_OFF 8'hFF
`define FPS_REG_ADDR_LSR 24'h00_0030
`define FPS_REG_ADDR_PTR 24'h00_0040
`define FPS_BLOCKS 512
`endif

// ==== rtl/fps_pkg.sv ====
`default_nettype none
package fps_pkg;
   typedef enum logic [1:0] {
      FPS_ST_IDLE, FPS_ST_ADDR, FPS_ST_DATA, FPS_ST_SKIP
   } fps_state_type;
   typedef enum logic [3:0] {
      FPS_CMD_NONE, FPS_CMD_LSR_READ, FPS_CMD_LSR_LOCK, FPS_CMD_READ_ANY_REGISTER,
      FPS_CMD_WRITE_ANY_REGISTER, FPS_CMD_SL_READ, FPS_CMD_SL_LOCK, FPS_CMD_SL_UNLOCK,
      FPS_CMD_GLOCK, FPS_CMD_GUNLOCK, FPS_CMD_PTR_SET, FPS_CMD_PROG_ERASE
   } fps_cmd_type;
endpackage
`default_nettype wire

// ==== rtl/fps_link_if.sv ====
`default_nettype none
interface fps_link_if;
   logic [7:0] rx_byte;
   logic rx_toggle;
   logic [7:0] tx_byte;
   modport link (output rx_byte, output rx_toggle, input tx_byte);
   modport core (input rx_byte, input rx_toggle, output tx_byte);
endinterface
`default_nettype wire

// ==== rtl/fps_sync.sv ====
`default_nettype none
module fps_sync #(parameter bit RESET_VAL = 1'b0) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic d,
   output logic q
);
   logic meta_reg;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_reg <= RESET_VAL;
         q <= RESET_VAL;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// ==== rtl/fps_spi_link.sv ====
`default_nettype none
module fps_spi_link (
   input wire logic sck,
   input wire logic cs_n,
   input wire logic reset_n,
   input wire logic si,
   output logic so,
   output logic so_oe,
   fps_link_if.link lnk
);
   logic [2:0] bit_cnt_reg;
   logic [6:0] in_sh_reg;
   logic [7:0] out_sh_reg;
   // frame state is cleared by cs_n itself, sck may stop between frames
   always_ff @(posedge sck or posedge cs_n) begin
      if (cs_n) begin
         bit_cnt_reg <= 3'h0;
         in_sh_reg <= 7'h00;
      end else begin
         bit_cnt_reg <= bit_cnt_reg + 3'h1;
         in_sh_reg <= {in_sh_reg[5:0], si};
      end
   end
   // byte and toggle survive the frame end, so the core never misses one
   always_ff @(posedge sck or negedge reset_n) begin
      if (!reset_n) begin
         lnk.rx_byte <= 8'h00;
         lnk.rx_toggle <= 1'b0;
      end else if (bit_cnt_reg == 3'h7) begin
         lnk.rx_byte <= {in_sh_reg, si};
         lnk.rx_toggle <= ~lnk.rx_toggle;
      end
   end
   // tx byte is held by the core for a whole byte time before it is loaded
   always_ff @(negedge sck or posedge cs_n) begin
      if (cs_n) begin
         out_sh_reg <= 8'h00;
      end else if (bit_cnt_reg == 3'h0) begin
         out_sh_reg <= lnk.tx_byte;
      end else begin
         out_sh_reg <= {out_sh_reg[6:0], 1'b0};
      end
   end
   assign so = out_sh_reg[7];
   assign so_oe = ~cs_n;
endmodule
`default_nettype wire

// ==== dv/fps_protect_chk.sv ====
`default_nettype none
module fps_protect_chk #(
   parameter bit LARGE_DENSITY = 1'b1
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic cs_n,
   input wire logic so_oe,
   input wire logic [7:0] region_mode,
   input wire logic pe_start,
   input wire logic pe_denied,
   input wire logic [31:0] pe_addr,
   input wire logic [7:0] lock_status,
   input wire logic [31:0] pointer_config
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   property p_oe;
      so_oe == !cs_n;
   endproperty
   a_oe: assert property (p_oe) else $error("so_oe off");
   property p_pe_one;
      !(pe_start && pe_denied);
   endproperty
   a_pe_one: assert property (p_pe_one) else $error("both pe");
   property p_start_pulse;
      pe_start |=> !pe_start;
   endproperty
   a_start_pulse: assert property (p_start_pulse)
      else $error("start");
   property p_deny_pulse;
      pe_denied |=> !pe_denied;
   endproperty
   a_deny_pulse: assert property (p_deny_pulse) else $error("deny");
   property p_pe_frame;
      (pe_start || pe_denied) |-> cs_n && $past(cs_n, 3);
   endproperty
   a_pe_frame: assert property (p_pe_frame) else $error("pe early");
   property p_pe_addr;
      $changed(pe_addr) |-> pe_start || pe_denied;
   endproperty
   a_pe_addr: assert property (p_pe_addr) else $error("pe_addr");
   property p_lsr_rsvd;
      lock_status[7] == 1'b0 && lock_status[5:1] == 5'h00;
   endproperty
   a_lsr_rsvd: assert property (p_lsr_rsvd) else $error("lsr rsvd");
   property p_mirror;
      $past(reset_n, 3) |-> lock_status[6] == region_mode[6];
   endproperty
   a_mirror: assert property (p_mirror) else $error("bit 6");
   property p_cfg_rise;
      $rose(lock_status[0]) |-> region_mode[2] && region_mode[0];
   endproperty
   a_cfg_rise: assert property (p_cfg_rise) else $error("cfg lock");
   property p_frozen;
      !lock_status[0] |=> $stable(pointer_config);
   endproperty
   a_frozen: assert property (p_frozen) else $error("ptr moved");
   property p_ptr_rsvd;
      pointer_config[31:25] == 7'h7F && pointer_config[8:0] == 9'h1FF &&
         (LARGE_DENSITY || pointer_config[24]);
   endproperty
   a_ptr_rsvd: assert property (p_ptr_rsvd) else $error("ptr rsvd");
   c_deny: cover property (pe_denied);
   c_start: cover property (pe_start);
   c_ptr: cover property ($changed(pointer_config));
endmodule
bind fps_protect fps_protect_chk #(.LARGE_DENSITY(LARGE_DENSITY))
   fps_protect_chk_i (.clk(clk), .reset_n(reset_n), .cs_n(cs_n),
   .so_oe(so_oe), .region_mode(region_mode), .pe_start(pe_start),
   .pe_denied(pe_denied), .pe_addr(pe_addr), .lock_status(lock_status),
   .pointer_config(pointer_config));
`default_nettype wire

// ==== dv/fps_host_model.sv ====
`default_nettype none
module fps_host_model (
   output logic sck,
   output logic cs_n,
   output logic si,
   input wire logic so,
   output logic [7:0] rd_byte,
   output logic rd_tgl
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
      rd_byte = 8'h00;
      rd_tgl = 1'b0;
   end
   // sck stands still between frames; idle si shows the inverse bit
   task automatic frame(input logic [7:0] q[$], input bit rd);
      logic [7:0] sh;
      sh = 8'h00;
      // odd offset lets the link phase drift against the core clock
      #3.3 cs_n = 1'b0;
      #30;
      foreach (q[i]) begin
         for (int b = 7; b >= 0; b--) begin
            si = q[i][b];
            #15 sck = 1'b1;
            sh = {sh[6:0], so};
            #15 sck = 1'b0;
         end
      end
      #15 cs_n = 1'b1;
      si = ~si;
      if (rd) begin
         rd_byte = sh;
         rd_tgl = ~rd_tgl;
      end
      #80;
   endtask
endmodule
`default_nettype wire

// ==== dv/fps_protect_bench.sv ====
`default_nettype none
module fps_protect_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, reset_n, sck, cs_n, si, so, so_oe, pe_start, pe_denied, rd_tgl;
   logic [7:0] region_mode, lock_status, rd_byte, m, lsr, dflt;
   logic [31:0] pe_addr, pointer_config, a, ra;
   logic [33:0] exp_q[$];
   logic [7:0] fq[$];
   logic [7:0] modes[3] = '{8'hAE, 8'hFB, 8'hFF};
   logic [7:0] ops[6] = '{8'h39, 8'h36, 8'hE2, 8'hE1, 8'h98, 8'h7E};
   logic [7:0] pes[6] = '{8'h02, 8'h12, 8'h20, 8'h21, 8'hD8, 8'hDC};
   logic [31:0] pv[4] = '{32'h0012_3000, 32'h0012_3200, 32'h0012_3800,
      32'h0012_3400};
   logic [1:0] dv[4] = '{2'h2, 2'h1, 2'h3, 2'h0};
   int fail_count = 0;
   int checked = 0;
   int seed = 89066;
   fps_protect fps_protect_i (.clk(clk), .reset_n(reset_n), .sck(sck),
      .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe),
      .region_mode(region_mode), .pe_start(pe_start), .pe_denied(pe_denied),
      .pe_addr(pe_addr), .lock_status(lock_status),
      .pointer_config(pointer_config));
   fps_host_model fps_host_model_i (.sck(sck), .cs_n(cs_n), .si(si),
      .so(so), .rd_byte(rd_byte), .rd_tgl(rd_tgl));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] e);
      checked++;
      if (got !== e) begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, e);
      end
   endtask
   task automatic take(input logic [33:0] got);
      logic [33:0] e;
      if (exp_q.size() == 0) begin
         fail_count++;
         $display("[ERR] %0t unexpected result %h", $time, got);
      end else begin
         e = exp_q.pop_front();
         chk({30'h0, got[33:32]}, {30'h0, e[33:32]});
         chk(got[31:0], e[31:0]);
      end
   endtask
   // mid-cycle look keeps clear of the edge that launches the pulse
   always @(negedge clk) begin
      if (pe_start === 1'b1 || pe_denied === 1'b1) begin
         take({pe_denied === 1'b1 ? 2'h2 : 2'h1, pe_addr});
      end
   end
   always @(rd_tgl) begin
      if ($time > 0) take({26'h0, rd_byte});
   end
   // nd of 2 means a dummy byte then the answer byte
   task automatic cmd(input logic [7:0] op, input logic [31:0] ad,
         input int nab, input int nd, input logic [7:0] d);
      fq = '{op};
      if (nab == 4) fq.push_back(ad[31:24]);
      if (nab > 0) fq.push_back(ad[23:16]);
      if (nab > 0) fq.push_back(ad[15:8]);
      if (nab > 0) fq.push_back(ad[7:0]);
      for (int i = 0; i < nd; i++) fq.push_back(d);
      fps_host_model_i.frame(fq, nd == 2);
   endtask
   task automatic rd_chk(input logic [7:0] op, input logic [31:0] ad,
         input int nab, input logic [7:0] e);
      exp_q.push_back({26'h0, e});
      cmd(op, ad, nab, 2, 8'h00);
   endtask
   task automatic prog(input logic [7:0] op, input logic [31:0] ad,
         input bit deny);
      int nab;
      nab = op inside {8'h12, 8'h21, 8'hDC} ? 4 : 3;
      exp_q.push_back({deny ? 2'h2 : 2'h1,
         nab == 4 ? ad[31:24] : 8'h00, ad[23:0]});
      cmd(op, ad, nab, 0, 8'h00);
   endtask
   task automatic rst(input logic [7:0] md);
      @(posedge clk);
      reset_n <= 1'b0;
      region_mode <= md;
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
   endtask
   task automatic test_done();
      $display("checked %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #400000;
      fail_count++;
      $display("[ERR] %0t watchdog expired", $time);
      test_done();
   end
   initial begin
      reset_n = 1'b0;
      region_mode = 8'hAE;
      foreach (modes[k]) begin
         m = modes[k];
         rst(m);
         lsr = {1'b0, m[6], 5'h00, m[2] & m[0]};
         dflt = m[4] ? 8'h00 : 8'hFF;
         chk({24'h0, lock_status}, {24'h0, lsr});
         chk(pointer_config, 32'hFFFF_FFFF);
         rd_chk(8'hA7, 32'h0, 0, lsr);
         rd_chk(8'h65, 32'h30, 3, lsr);
         cmd(8'h71, 32'h30, 3, 1, 8'hFF);
         cmd(8'hE3, pv[0], 4, 0, 8'h00);
         chk(pointer_config, lsr[0] ? pv[0] | 32'hFE00_01FF
            : 32'hFFFF_FFFF);
         cmd(8'hA6, 32'h0, 0, 0, 8'h00);
         chk({24'h0, lock_status}, {24'h0, lsr});
         cmd(8'hE3, 32'hFFFF_FFFF, 4, 0, 8'h00);
         ra = $random(seed);
         a = {8'h00, ra[23:0]};
         rd_chk(8'h3D, a, 3, dflt);
         prog(8'h02, a, dflt == 8'h00);
         $display("test mode %h done", m);
      end
      for (int i = 0; i < 6; i++) begin
         cmd(ops[i], a, ops[i] inside {8'h7E, 8'h98} ? 0
            : (ops[i] inside {8'hE1, 8'hE2} ? 4 : 3), 0, 8'h00);
         rd_chk(i[0] ? 8'h3D : 8'hE0, a, i[0] ? 3 : 4,
            i[0] ? 8'h00 : 8'hFF);
         prog(pes[i], a, i[0]);
      end
      $display("test locks done");
      cmd(8'h98, 32'h0, 0, 0, 8'h00);
      foreach (pv[j]) begin
         cmd(8'hE3, pv[j], 4, 0, 8'h00);
         chk(pointer_config, pv[j] | 32'hFE00_01FF);
         prog(8'h02, 32'h0013_0000, dv[j][1]);
         prog(8'hD8, 32'h0010_0000, dv[j][0]);
      end
      cmd(8'hFB, 32'h0012_3000, 3, 0, 8'h00);
      chk(pointer_config, 32'hFF12_31FF);
      rd_chk(8'h65, 32'h41, 3, 8'h31);
      cmd(8'h71, 32'h41, 3, 1, 8'h20);
      chk(pointer_config, 32'hFF12_21FF);
      $display("test pointer done");
      repeat (20) @(posedge clk);
      chk(exp_q.size(), 32'h0);
      test_done();
   end
endmodule
`default_nettype wire
